// file: core/spa_pkg.sv
// shared constants and types for the slave parameter access unit
package spa_pkg;
	localparam int AXIS_W    = 8;
	localparam int INDEX_W   = 16;
	localparam int SUBIDX_W  = 8;
	localparam int WIDTH_W   = 8;
	localparam int VALUE_W   = 32;
	localparam int FAULT_W   = 16;

	localparam logic [AXIS_W-1:0]   AXIS_NONE    = 8'h00;
	localparam logic [WIDTH_W-1:0]  WIDTH_BYTE   = 8'h01;
	localparam logic [WIDTH_W-1:0]  WIDTH_WORD   = 8'h02;
	localparam logic [WIDTH_W-1:0]  WIDTH_DWORD  = 8'h04;
	localparam logic [WIDTH_W-1:0]  WIDTH_CLEAR  = 8'h00;
	localparam logic [VALUE_W-1:0]  VALUE_CLEAR  = 32'h0000_0000;
	localparam logic [FAULT_W-1:0]  FAULT_NONE   = 16'h0000;
	// local fault codes, values are arbitrary
	localparam logic [FAULT_W-1:0]  FAULT_AXIS   = 16'h0a01;
	localparam logic [FAULT_W-1:0]  FAULT_WIDTH  = 16'h0a02;
	localparam logic [FAULT_W-1:0]  FAULT_SLAVE  = 16'h0a03;

	typedef enum logic [1:0]
	{
		SPA_IDLE,
		SPA_WAIT,
		SPA_DONE,
		SPA_FAULT
	} spa_state_t;
endpackage

// file: core/spa_param_access.sv
// request unit that reads or writes one parameter of a networked servo slave
`timescale 1ns/1ps

module spa_param_access
	import spa_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire logic                        start,
	input  wire logic                        write_sel,
	input  wire logic [spa_pkg::AXIS_W-1:0]  axis,
	input  wire logic [spa_pkg::INDEX_W-1:0] obj_index,
	input  wire logic [spa_pkg::SUBIDX_W-1:0] obj_subindex,
	input  wire logic [spa_pkg::WIDTH_W-1:0] value_width_code,
	input  wire logic [spa_pkg::VALUE_W-1:0] write_value,
	output logic                             busy_q,
	output logic                             active_q,
	output logic                             done_q,
	output logic                             error_q,
	output logic [spa_pkg::FAULT_W-1:0]      fault_code_q,
	output logic [spa_pkg::WIDTH_W-1:0]      read_width_q,
	output logic [spa_pkg::VALUE_W-1:0]      read_value_q,
	output logic                             slv_req_q,
	output logic                             slv_write_q,
	output logic [spa_pkg::AXIS_W-1:0]       slv_axis_q,
	output logic [spa_pkg::INDEX_W-1:0]      slv_index_q,
	output logic [spa_pkg::SUBIDX_W-1:0]     slv_subindex_q,
	output logic [spa_pkg::WIDTH_W-1:0]      slv_width_q,
	output logic [spa_pkg::VALUE_W-1:0]      slv_wdata_q,
	input  wire logic                        slv_ack,
	input  wire logic                        slv_fail,
	input  wire logic [spa_pkg::FAULT_W-1:0] slv_fault_code,
	input  wire logic [spa_pkg::WIDTH_W-1:0] slv_rwidth,
	input  wire logic [spa_pkg::VALUE_W-1:0] slv_rdata
);
	import spa_pkg::*;

	spa_state_t           state_q;
	logic                 start_prev_q;
	logic                 start_rise;
	logic                 width_ok;
	logic                 axis_ok;
	logic                 inputs_ok;
	logic                 finish;
	logic [FAULT_W-1:0]   start_fault;

	assign start_rise = start && !start_prev_q;
	assign axis_ok    = axis != AXIS_NONE;
	// width is only meaningful on a write; a read learns it from the slave
	assign width_ok   = !write_sel || value_width_code == WIDTH_BYTE
		|| value_width_code == WIDTH_WORD || value_width_code == WIDTH_DWORD;
	assign inputs_ok  = axis_ok && width_ok;
	assign start_fault = axis_ok ? FAULT_WIDTH : FAULT_AXIS;
	assign finish     = state_q == SPA_WAIT && slv_ack;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			start_prev_q <= 1'b0;
		else
			start_prev_q <= start;
	end

	// sequencer; a second start edge while busy is ignored
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state_q <= SPA_IDLE;
		else
		begin
			unique case (state_q)
				SPA_IDLE:
					if (start_rise)
						state_q <= inputs_ok ? SPA_WAIT : SPA_FAULT;
				SPA_WAIT:
					if (slv_ack)
						state_q <= slv_fail ? SPA_FAULT : SPA_DONE;
				SPA_DONE:
					if (!start)
						state_q <= SPA_IDLE;
				SPA_FAULT:
					if (!start)
						state_q <= SPA_IDLE;
			endcase
		end
	end

	// busy and active share one span: the slave is held only while waiting
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			busy_q   <= 1'b0;
			active_q <= 1'b0;
		end
		else if (state_q == SPA_IDLE && start_rise && inputs_ok)
		begin
			busy_q   <= 1'b1;
			active_q <= 1'b1;
		end
		else if (finish)
		begin
			busy_q   <= 1'b0;
			active_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			done_q <= 1'b0;
		else if (finish && !slv_fail)
			done_q <= 1'b1;
		else if (state_q == SPA_DONE && !start)
			done_q <= 1'b0;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			error_q      <= 1'b0;
			fault_code_q <= FAULT_NONE;
		end
		else if (state_q == SPA_IDLE && start_rise && !inputs_ok)
		begin
			error_q      <= 1'b1;
			fault_code_q <= start_fault;
		end
		else if (finish && slv_fail)
		begin
			error_q      <= 1'b1;
			// a slave that reports no code still yields a nonzero fault
			fault_code_q <= slv_fault_code == FAULT_NONE ? FAULT_SLAVE : slv_fault_code;
		end
		else if (state_q == SPA_FAULT && !start)
		begin
			error_q      <= 1'b0;
			fault_code_q <= FAULT_NONE;
		end
	end

	// read results persist until the next read finishes or fails
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			read_width_q <= WIDTH_CLEAR;
			read_value_q <= VALUE_CLEAR;
		end
		else if (state_q == SPA_IDLE && start_rise && !inputs_ok && !write_sel)
		begin
			read_width_q <= WIDTH_CLEAR;
			read_value_q <= VALUE_CLEAR;
		end
		else if (finish && !slv_write_q)
		begin
			read_width_q <= slv_fail ? WIDTH_CLEAR : slv_rwidth;
			read_value_q <= slv_fail ? VALUE_CLEAR : slv_rdata;
		end
	end

	// request to the slave, fields frozen at the start edge
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			slv_req_q      <= 1'b0;
			slv_write_q    <= 1'b0;
			slv_axis_q     <= AXIS_NONE;
			slv_index_q    <= '0;
			slv_subindex_q <= '0;
			slv_width_q    <= WIDTH_CLEAR;
			slv_wdata_q    <= VALUE_CLEAR;
		end
		else if (state_q == SPA_IDLE && start_rise && inputs_ok)
		begin
			slv_req_q      <= 1'b1;
			slv_write_q    <= write_sel;
			slv_axis_q     <= axis;
			slv_index_q    <= obj_index;
			slv_subindex_q <= obj_subindex;
			slv_width_q    <= value_width_code;
			slv_wdata_q    <= write_value;
		end
		else if (finish)
			slv_req_q <= 1'b0;
	end

	sequence s_good_start;
		state_q == SPA_IDLE && start_rise && inputs_ok;
	endsequence

	sequence s_done_rise;
		!done_q ##1 done_q;
	endsequence

	sequence s_bad_start;
		state_q == SPA_IDLE && start_rise && !inputs_ok;
	endsequence

	a_start_busy_act: assert property (@(posedge clk) disable iff (!rstn)
		s_good_start |=> busy_q && active_q && slv_req_q)
		else $error("busy or active missing after start edge");

	a_done_drops_busy: assert property (@(posedge clk) disable iff (!rstn)
		s_done_rise |-> !busy_q && !active_q && $past(busy_q))
		else $error("busy or active still high when done rose");

	a_read_data_shown: assert property (@(posedge clk) disable iff (!rstn)
		finish && !slv_fail && !slv_write_q |=> done_q && read_value_q == $past(slv_rdata)
			&& read_width_q == $past(slv_rwidth))
		else $error("read result not shown with done");

	a_done_clears: assert property (@(posedge clk) disable iff (!rstn)
		done_q && state_q == SPA_DONE && !start |=> !done_q && $stable(read_value_q))
		else $error("done not cleared or read value changed");

	a_read_err_zero: assert property (@(posedge clk) disable iff (!rstn)
		finish && slv_fail && !slv_write_q |=> error_q && read_width_q == WIDTH_CLEAR
			&& read_value_q == VALUE_CLEAR)
		else $error("read outputs not zeroed on error");

	a_illegal_axis: assert property (@(posedge clk) disable iff (!rstn)
		state_q == SPA_IDLE && start_rise && axis == AXIS_NONE |=> error_q && !busy_q
			&& !slv_req_q && fault_code_q == FAULT_AXIS)
		else $error("axis zero did not raise error");

	a_err_has_code: assert property (@(posedge clk) disable iff (!rstn)
		error_q |-> fault_code_q != FAULT_NONE)
		else $error("error without fault code");

	a_err_clears: assert property (@(posedge clk) disable iff (!rstn)
		error_q && state_q == SPA_FAULT && !start |=> !error_q && fault_code_q == FAULT_NONE)
		else $error("error not cleared on start fall");

	a_write_waits_ack: assert property (@(posedge clk) disable iff (!rstn)
		s_done_rise |-> $past(slv_ack) && !$past(slv_fail))
		else $error("done rose without slave acceptance");

	a_active_span: assert property (@(posedge clk) disable iff (!rstn)
		active_q |-> state_q == SPA_WAIT && slv_req_q)
		else $error("active outside slave control");

	a_err_no_done: assert property (@(posedge clk) disable iff (!rstn)
		error_q |-> !done_q && !busy_q && !active_q)
		else $error("error together with done or busy");

	a_axis_held: assert property (@(posedge clk) disable iff (!rstn)
		slv_req_q && !$rose(slv_req_q) |-> $stable(slv_axis_q))
		else $error("slave selection changed mid transfer");

	a_width_fault: assert property (@(posedge clk) disable iff (!rstn)
		s_bad_start ##0 axis_ok |=> error_q && !slv_req_q && fault_code_q == FAULT_WIDTH)
		else $error("bad write width did not raise error");

	a_good_no_error: assert property (@(posedge clk) disable iff (!rstn)
		s_good_start |=> !error_q && !done_q)
		else $error("error or done raised by a legal start");

	// a clear and a new set never meet: the clear needs SPA_FAULT, a set needs SPA_IDLE or SPA_WAIT
	a_no_stray_error: assert property (@(posedge clk) disable iff (!rstn)
		!error_q && !(finish && slv_fail) && !(state_q == SPA_IDLE && start_rise && !inputs_ok)
			|=> !error_q)
		else $error("error rose without a cause");

	a_fail_no_done: assert property (@(posedge clk) disable iff (!rstn)
		finish && slv_fail |=> error_q && !done_q && !busy_q && !active_q)
		else $error("slave failure did not end the request with error");

	a_idle_quiet: assert property (@(posedge clk) disable iff (!rstn)
		state_q == SPA_IDLE |-> !busy_q && !active_q && !slv_req_q && !done_q)
		else $error("busy, active or done while idle");

	a_fields_held: assert property (@(posedge clk) disable iff (!rstn)
		slv_req_q && !$rose(slv_req_q) |-> $stable(slv_index_q) && $stable(slv_subindex_q)
			&& $stable(slv_wdata_q) && $stable(slv_width_q) && $stable(slv_write_q))
		else $error("request fields changed mid transfer");

	a_write_keeps_read: assert property (@(posedge clk) disable iff (!rstn)
		finish && slv_write_q |=> $stable(read_value_q) && $stable(read_width_q))
		else $error("write disturbed the read result");

	a_req_ends: assert property (@(posedge clk) disable iff (!rstn)
		finish |=> !slv_req_q && !busy_q)
		else $error("slave request still held after acceptance");
endmodule

// file: verification/spa_slave_model.sv
// behavioural servo slave answering the unit's parameter requests
`timescale 1ns/1ps
module spa_slave_model
	import spa_pkg::*;
(
	input  wire logic                         clk,
	input  wire logic                         rstn,
	input  wire logic                         slv_req_q,
	input  wire logic                         slv_write_q,
	input  wire logic [spa_pkg::WIDTH_W-1:0]  slv_width_q,
	input  wire logic [spa_pkg::VALUE_W-1:0]  slv_wdata_q,
	input  wire logic [spa_pkg::WIDTH_W-1:0]  pwidth,
	input  wire logic [3:0]                   dly,
	input  wire logic                         bad,
	output logic                              slv_ack,
	output logic                              slv_fail,
	output logic [spa_pkg::FAULT_W-1:0]       slv_fault_code,
	output logic [spa_pkg::WIDTH_W-1:0]       slv_rwidth,
	output logic [spa_pkg::VALUE_W-1:0]       slv_rdata
);
	logic [3:0]                  cnt_q;
	logic [spa_pkg::VALUE_W-1:0] param_q;
	// outside the ack cycle the read lines carry inverted data, never a stale copy
	assign slv_rwidth = slv_ack ? pwidth : ~pwidth;
	assign slv_rdata  = slv_ack ? param_q : ~param_q;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt_q <= 4'h0;
			slv_ack <= 1'b0;
			slv_fail <= 1'b0;
			slv_fault_code <= 16'h0000;
			param_q <= 32'h0000_0000;
		end
		else
		begin
			slv_ack <= 1'b0;
			if (slv_req_q && !slv_ack)
			begin
				cnt_q <= cnt_q + 4'h1;
				if (cnt_q == dly)
				begin
					cnt_q <= 4'h0;
					slv_ack <= 1'b1;
					slv_fail <= bad || (slv_write_q && slv_width_q != pwidth);
					// a zero code on a forced fault checks the unit's substitute
					slv_fault_code <= bad ? 16'h0000 : 16'h0b10;
					if (slv_write_q && !bad && slv_width_q == pwidth)
						param_q <= slv_wdata_q;
				end
			end
		end
	end
endmodule

// file: verification/spa_param_access_tb_top.sv
// self-checking bench for the slave parameter access unit
`timescale 1ns/1ps
module spa_param_access_tb_top;
	import spa_pkg::*;
	logic                clk = 1'b0;
	logic                rstn, start, write_sel, bad, acked, busy_q, active_q, done_q, error_q;
	logic                slv_req_q, slv_write_q, slv_ack, slv_fail;
	logic [AXIS_W-1:0]   axis, slv_axis_q;
	logic [INDEX_W-1:0]  obj_index, slv_index_q;
	logic [SUBIDX_W-1:0] obj_subindex, slv_subindex_q;
	logic [WIDTH_W-1:0]  value_width_code, read_width_q, slv_width_q, slv_rwidth, pwidth;
	logic [VALUE_W-1:0]  write_value, read_value_q, slv_wdata_q, slv_rdata;
	logic [FAULT_W-1:0]  fault_code_q, slv_fault_code;
	logic [3:0]          dly;
	int                  err_count = 0, compares = 0, cyc = 0;

	spa_param_access i_dut (.clk(clk), .rstn(rstn), .start(start), .write_sel(write_sel),
		.axis(axis), .obj_index(obj_index), .obj_subindex(obj_subindex),
		.value_width_code(value_width_code), .write_value(write_value), .busy_q(busy_q),
		.active_q(active_q), .done_q(done_q), .error_q(error_q), .fault_code_q(fault_code_q),
		.read_width_q(read_width_q), .read_value_q(read_value_q), .slv_req_q(slv_req_q),
		.slv_write_q(slv_write_q), .slv_axis_q(slv_axis_q), .slv_index_q(slv_index_q),
		.slv_subindex_q(slv_subindex_q), .slv_width_q(slv_width_q), .slv_wdata_q(slv_wdata_q),
		.slv_ack(slv_ack), .slv_fail(slv_fail), .slv_fault_code(slv_fault_code),
		.slv_rwidth(slv_rwidth), .slv_rdata(slv_rdata));
	spa_slave_model i_slave (.clk(clk), .rstn(rstn), .slv_req_q(slv_req_q),
		.slv_write_q(slv_write_q), .slv_width_q(slv_width_q), .slv_wdata_q(slv_wdata_q),
		.pwidth(pwidth), .dly(dly), .bad(bad), .slv_ack(slv_ack), .slv_fail(slv_fail),
		.slv_fault_code(slv_fault_code), .slv_rwidth(slv_rwidth), .slv_rdata(slv_rdata));

	always #5 clk = ~clk;
	always @(posedge clk)
		if (slv_ack === 1'b1)
			acked <= 1'b1;
	// ceiling sits far above the roughly one hundred cycles the scenarios need
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_count++;
			end_sim();
		end
	end

	task automatic chk(input logic [63:0] exp, input logic [63:0] got);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	task automatic fire(input logic w, input logic [7:0] ax, input logic [7:0] wc,
		input logic [31:0] v);
		int n;
		logic ill;
		n = 0;
		// legal inputs: nonzero axis, and on a write a width code of 1, 2 or 4
		ill = ax == AXIS_NONE
			|| (w && wc != WIDTH_BYTE && wc != WIDTH_WORD && wc != WIDTH_DWORD);
		@(negedge clk);
		{write_sel, axis, value_width_code, write_value} = {w, ax, wc, v};
		acked = 1'b0;
		start = 1'b1;
		@(negedge clk);
		axis = 8'h55;
		if (ill)
			chk(2, {error_q, busy_q});
		else
			chk(3, {busy_q, active_q});
		@(negedge clk);
		if (!ill)
		begin
			chk(ax, slv_axis_q);
			chk({obj_index, obj_subindex, wc, v},
				{slv_index_q, slv_subindex_q, slv_width_q, slv_wdata_q});
		end
		while (done_q !== 1'b1 && error_q !== 1'b1 && n < 40)
		begin
			@(negedge clk);
			n++;
		end
		chk(0, {busy_q, active_q});
	endtask

	task automatic fin;
		@(negedge clk);
		start = 1'b0;
		@(negedge clk);
		chk(0, {done_q, error_q, fault_code_q});
	endtask

	task automatic t_write_read;
		for (int i = 0; i < 3; i++)
		begin
			pwidth = 8'h01 << i;
			dly = 4'(2 * i);
			fire(1'b1, 8'h01, pwidth, 32'h1000 + i);
			chk(3, {done_q, acked});
			chk(0, error_q);
			fin();
		end
		fire(1'b0, 8'h02, 8'h00, 32'h0);
		chk({1'b1, pwidth, 32'h1002}, {done_q, read_width_q, read_value_q});
		fin();
		chk({pwidth, 32'h1002}, {read_width_q, read_value_q});
	endtask

	task automatic t_faults;
		bad = 1'b1;
		fire(1'b0, 8'h03, 8'h00, 32'h0);
		chk({2'b01, 16'h0a03, 40'h0}, {done_q, error_q, fault_code_q, read_width_q, read_value_q});
		fin();
		bad = 1'b0;
		fire(1'b1, 8'h01, 8'h01, 32'h7);
		chk({1'b1, 16'h0b10}, {error_q, fault_code_q});
		fin();
		fire(1'b1, 8'h01, 8'h03, 32'h7);
		chk({1'b1, FAULT_WIDTH}, {error_q, fault_code_q});
		fin();
		fire(1'b1, AXIS_NONE, 8'h02, 32'h7);
		chk({1'b1, FAULT_AXIS}, {error_q, fault_code_q});
		fin();
	endtask

	task automatic t_reset;
		dly = 4'h8;
		@(negedge clk);
		{write_sel, axis} = {1'b0, 8'h04};
		start = 1'b1;
		repeat (3) @(negedge clk);
		rstn = 1'b0;
		@(negedge clk);
		chk(0, {busy_q, active_q, done_q, error_q, slv_req_q, read_value_q});
		{start, rstn} = 2'b01;
		fire(1'b0, 8'h04, 8'h00, 32'h0);
		chk({1'b1, pwidth, 32'h0}, {done_q, read_width_q, read_value_q});
		fin();
	endtask

	task automatic end_sim;
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial
	begin
		{rstn, start, write_sel, bad, acked, dly} = '0;
		{axis, value_width_code, write_value, pwidth} = '0;
		obj_index = 16'h2137;
		obj_subindex = 8'h00;
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		t_write_read();
		t_faults();
		t_reset();
		end_sim();
	end
endmodule
